// File: src/mdd_top.sv
// Dual DC motor drive control: mode pins, enable, fault and load
// flags, serial register access with auto-baud, gate drive.
// Assumes synchronous pin inputs on mclk and an AXI4-Lite master.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "mdd_map.svh"

module mdd_top import mdd_pkg::*; #(
  parameter int FRAME_TO = `MDD_FRAME_TO
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic io_supply_standby,
  input wire logic serial_mode_select,
  input wire logic mode_select_pin,
  input wire logic enable_pin,
  input wire logic addr_bit_low_pin,
  input wire logic addr_bit_high_pin,
  input wire logic bridge_a_pol_1,
  input wire logic bridge_a_pol_2,
  input wire logic pwm_hs_in,
  input wire logic ser_rx,
  output logic ser_tx,
  output logic ser_tx_oe,
  input wire logic bridge_a_foot_ocp,
  input wire logic bridge_b_foot_ocp,
  input wire logic [7:0] cur_a,
  input wire logic [7:0] cur_b,
  output logic [3:0] hs_gate,
  output logic [3:0] ls_gate,
  output logic fault_indicator_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [15:0] TO_LAST = 16'(FRAME_TO - 1);

  // ----------------------------------------
  // Pin sampling and state
  // ----------------------------------------
  // Standby acts as synchronous clear
  wire stby = ~io_supply_standby;
  // Half-bridge mode reuses the address pins as B polarity
  wire bridge_b_pol_1 = addr_bit_low_pin;
  wire bridge_b_pol_2 = addr_bit_high_pin;

  mdd_mode_t mode_r;
  mdd_fr_t fr_r;
  logic [1:0] node_r;
  logic par_r;
  logic [7:0] duty_a_r;
  logic [7:0] duty_b_r;
  logic [7:0] ilim_r;
  logic fault_r;
  logic load_r;
  logic fault_indicator_out_r;
  logic [3:0] hs_r;
  logic [3:0] ls_r;
  logic [7:0] crc_r;
  logic [7:0] idx_r;
  logic [7:0] dat_r;
  logic [7:0] txb_r;
  logic wr_r;
  logic hit_r;
  logic go_r;
  logic [15:0] to_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [7:0] awa_r;
  logic [7:0] wd_r;
  logic ws_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [7:0] rdata_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= MD_TEST0;
      node_r <= 2'b00;
    end else begin
      mode_r <= mdd_mode_t'({serial_mode_select, mode_select_pin});
      node_r <= {addr_bit_high_pin, addr_bit_low_pin};
    end
  end

  wire ser_mode = (mode_r == MD_SER);
  wire ser_clr = stby | ~ser_mode;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[7] ^ d[i]) begin
        r = {r[6:0], 1'b0} ^ `MDD_CRC_POLY;
      end else begin
        r = {r[6:0], 1'b0};
      end
    end
    return r;
  endfunction

  wire lim_a;
  wire lim_b;
  wire [7:0] stat_v = {node_r, mode_r, lim_b, lim_a, load_r, fault_r};

  function automatic logic [8:0] reg_read(input logic [7:0] a);
    logic [8:0] v;
    v = 9'h000;
    case (a)
      `MDD_REG_CTRL: v = {8'h80, par_r};
      `MDD_REG_DUTY_A: v = {1'b1, duty_a_r};
      `MDD_REG_DUTY_B: v = {1'b1, duty_b_r};
      `MDD_REG_ILIM: v = {1'b1, ilim_r};
      `MDD_REG_STAT: v = {1'b1, stat_v};
      default: v = 9'h000;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // Serial frame handling
  // ----------------------------------------
  wire [7:0] rx_byte;
  wire rx_stb;
  wire tx_busy;
  wire tx_line;
  wire tx_oe;
  wire crc_ok = (rx_byte == crc_r);
  wire [7:0] ser_wa = {idx_r[5:0], 2'b00};
  wire [8:0] ser_rv = reg_read(ser_wa);
  wire fr_end = (fr_r == FR_CRC) && rx_stb && crc_ok && hit_r;
  wire ser_we = fr_end && wr_r;
  wire ser_rd = fr_end && !wr_r;

  mdd_uart u_uart (
    .clk(mclk),
    .nrst(nrst),
    .clr(ser_clr),
    .autobaud(fr_r == FR_SYNC),
    .rx(ser_rx),
    .rx_byte(rx_byte),
    .rx_stb(rx_stb),
    .tx_go(go_r),
    .tx_byte(txb_r),
    .tx_busy(tx_busy),
    .tx_line(tx_line),
    .tx_oe(tx_oe)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fr_r <= FR_SYNC;
      crc_r <= 8'h00;
      idx_r <= 8'h00;
      dat_r <= 8'h00;
      txb_r <= 8'h00;
      wr_r <= 1'b0;
      hit_r <= 1'b0;
      go_r <= 1'b0;
      to_r <= 16'h0000;
    end else if (ser_clr) begin
      fr_r <= FR_SYNC;
      go_r <= 1'b0;
      to_r <= 16'h0000;
    end else begin
      go_r <= 1'b0;
      // Stalled frames resynchronise after a silent gap
      if (rx_stb || tx_busy || fr_r == FR_SYNC) begin
        to_r <= 16'h0000;
      end else begin
        to_r <= to_r + 16'h0001;
      end
      if (to_r == TO_LAST) begin
        fr_r <= FR_SYNC;
      end else begin
        unique case (fr_r)
          FR_SYNC: begin
            if (rx_stb && rx_byte == `MDD_SYNC) begin
              crc_r <= crc8(8'h00, rx_byte);
              fr_r <= FR_ADDR;
            end
          end
          FR_ADDR: begin
            if (rx_stb) begin
              crc_r <= crc8(crc_r, rx_byte);
              wr_r <= rx_byte[`MDD_RW_BIT];
              hit_r <= (rx_byte[1:0] == node_r);
              fr_r <= FR_REG;
            end
          end
          FR_REG: begin
            if (rx_stb) begin
              crc_r <= crc8(crc_r, rx_byte);
              idx_r <= rx_byte;
              fr_r <= wr_r ? FR_DATA : FR_CRC;
            end
          end
          FR_DATA: begin
            if (rx_stb) begin
              crc_r <= crc8(crc_r, rx_byte);
              dat_r <= rx_byte;
              fr_r <= FR_CRC;
            end
          end
          FR_CRC: begin
            if (ser_rd) begin
              txb_r <= ser_rv[7:0];
              go_r <= 1'b1;
              fr_r <= FR_TXD;
            end else if (rx_stb) begin
              fr_r <= FR_SYNC;
            end
          end
          FR_TXD: begin
            if (!tx_busy && !go_r) begin
              txb_r <= crc8(8'h00, txb_r);
              go_r <= 1'b1;
              fr_r <= FR_TXC;
            end
          end
          FR_TXC: begin
            if (!tx_busy && !go_r) begin
              fr_r <= FR_SYNC;
            end
          end
          default: fr_r <= FR_SYNC;
        endcase
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  wire aw_hs = s_axi_awvalid & awready_r;
  wire w_hs = s_axi_wvalid & wready_r;
  wire wr_go = ~awready_r & ~wready_r & ~bvalid_r;
  wire axi_we = wr_go & ws_r;
  wire [8:0] axi_rv = reg_read(s_axi_araddr);
  wire [8:0] aw_rv = reg_read(awa_r);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `MDD_RESP_OKAY;
      awa_r <= 8'h00;
      wd_r <= 8'h00;
      ws_r <= 1'b0;
    end else begin
      if (aw_hs) begin
        awa_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (w_hs) begin
        wd_r <= s_axi_wdata[7:0];
        ws_r <= s_axi_wstrb[0];
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= aw_rv[8] ? `MDD_RESP_OKAY : `MDD_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `MDD_RESP_OKAY;
      rdata_r <= 8'h00;
    end else if (s_axi_arvalid && arready_r) begin
      rdata_r <= axi_rv[7:0];
      rresp_r <= axi_rv[8] ? `MDD_RESP_OKAY : `MDD_RESP_SLVERR;
      rvalid_r <= 1'b1;
      arready_r <= 1'b0;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Serial write wins a same-cycle clash; the bus write is dropped
  wire cfg_we = ser_we | axi_we;
  wire [7:0] cfg_wa = ser_we ? ser_wa : awa_r;
  wire [7:0] cfg_wd = ser_we ? dat_r : wd_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      par_r <= `MDD_PAR_RST;
      duty_a_r <= `MDD_DUTY_RST;
      duty_b_r <= `MDD_DUTY_RST;
      ilim_r <= `MDD_ILIM_RST;
    end else if (stby) begin
      par_r <= `MDD_PAR_RST;
      duty_a_r <= `MDD_DUTY_RST;
      duty_b_r <= `MDD_DUTY_RST;
      ilim_r <= `MDD_ILIM_RST;
    end else if (cfg_we) begin
      case (cfg_wa)
        `MDD_REG_CTRL: par_r <= cfg_wd[`MDD_CTRL_PAR];
        `MDD_REG_DUTY_A: duty_a_r <= cfg_wd;
        `MDD_REG_DUTY_B: duty_b_r <= cfg_wd;
        `MDD_REG_ILIM: ilim_r <= cfg_wd;
        default: par_r <= par_r;
      endcase
    end
  end

  // ----------------------------------------
  // Motor PWM and current limit
  // ----------------------------------------
  // Standby floats the stage as well, whatever the enable pin says
  wire pwr_on = enable_pin & ~fault_r & ~stby;
  wire run = pwr_on & ser_mode;
  wire hit_a = (cur_a >= ilim_r);
  wire hit_b = (cur_b >= ilim_r);
  wire lim_in_a = run & (hit_a | (par_r & hit_b));
  wire lim_in_b = run & (par_r ? (hit_a | hit_b) : hit_b);
  wire [7:0] duty_b_eff = par_r ? duty_a_r : duty_b_r;
  wire [1:0] pw_hs_a;
  wire [1:0] pw_ls_a;
  wire [1:0] pw_hs_b;
  wire [1:0] pw_ls_b;

  mdd_pwm u_pwm_a (
    .clk(mclk),
    .nrst(nrst),
    .run(run),
    .duty(duty_a_r),
    .limit(lim_in_a),
    .hs(pw_hs_a),
    .ls(pw_ls_a),
    .cut(lim_a)
  );

  mdd_pwm u_pwm_b (
    .clk(mclk),
    .nrst(nrst),
    .run(run),
    .duty(duty_b_eff),
    .limit(lim_in_b),
    .hs(pw_hs_b),
    .ls(pw_ls_b),
    .cut(lim_b)
  );

  // ----------------------------------------
  // Fault, load and diagnostic flags
  // ----------------------------------------
  wire ocp = bridge_a_foot_ocp | bridge_b_foot_ocp;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fault_r <= 1'b0;
      load_r <= 1'b0;
      fault_indicator_out_r <= 1'b0;
    end else if (stby || !enable_pin) begin
      fault_r <= 1'b0;
      load_r <= 1'b0;
      // Fault_indicator_out returns low on enable low
      fault_indicator_out_r <= 1'b0;
    end else begin
      if (ocp && mode_r != MD_TEST0 && mode_r != MD_TEST1) begin
        fault_r <= 1'b1;
      end
      if (lim_in_a || lim_in_b) begin
        load_r <= 1'b1;
      end
      fault_indicator_out_r <= fault_indicator_out_r | fault_r | load_r;
    end
  end

  // ----------------------------------------
  // Gate drive selection
  // ----------------------------------------
  wire [3:0] pol = {bridge_b_pol_2, bridge_b_pol_1,
                    bridge_a_pol_2, bridge_a_pol_1};
  // Shared PWM gates high sides only
  wire [3:0] hb_hs = pol & {4{pwm_hs_in}};
  wire [3:0] hb_ls = ~pol;
  // Serial mode uses PWM, not pins
  wire [3:0] sr_hs = {pw_hs_b, pw_hs_a};
  wire [3:0] sr_ls = {pw_ls_b, pw_ls_a};
  wire half_mode = (mode_r == MD_HALF);
  // Enable low or fault floats outputs
  wire [3:0] hs_nxt = !pwr_on ? 4'h0 :
                      ser_mode ? sr_hs :
                      half_mode ? hb_hs : 4'h0;
  wire [3:0] ls_nxt = !pwr_on ? 4'h0 :
                      ser_mode ? sr_ls :
                      half_mode ? hb_ls : 4'h0;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hs_r <= 4'h0;
      ls_r <= 4'h0;
    end else begin
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hs_gate = hs_r;
  assign ls_gate = ls_r;
  assign fault_indicator_out = fault_indicator_out_r;
  assign ser_tx = tx_line;
  assign ser_tx_oe = tx_oe;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = {24'h000000, rdata_r};

endmodule

// File: inc/mdd_map.svh
// Offsets, fields, reset values and timing for the motor drive control.
// Definitions only; included by every design file that needs them.
`ifndef MDD_MAP_SVH
`define MDD_MAP_SVH

`define MDD_CLK_HZ 10000000
`define MDD_BAUD_MIN 9600
`define MDD_BAUD_MAX 500000
`define MDD_BIT_MAX (`MDD_CLK_HZ / `MDD_BAUD_MIN)
`define MDD_BIT_MIN (`MDD_CLK_HZ / `MDD_BAUD_MAX)
`define MDD_FRAME_TO_US 2000
`define MDD_FRAME_TO ((`MDD_CLK_HZ / 1000000) * `MDD_FRAME_TO_US)

`define MDD_SYNC 8'h55
`define MDD_CRC_POLY 8'h07
`define MDD_RW_BIT 7

`define MDD_REG_CTRL 8'h00
`define MDD_REG_DUTY_A 8'h04
`define MDD_REG_DUTY_B 8'h08
`define MDD_REG_ILIM 8'h0C
`define MDD_REG_STAT 8'h10

`define MDD_CTRL_PAR 0
`define MDD_PAR_RST 1'b0
`define MDD_DUTY_RST 8'h00
`define MDD_ILIM_RST 8'hFF

`define MDD_RESP_OKAY 2'h0
`define MDD_RESP_SLVERR 2'h2

`endif

// File: inc/mdd_pkg.sv
// Types shared by the motor drive control files.
// No assumptions beyond a SystemVerilog compiler.
package mdd_pkg;

  typedef enum logic [1:0] {
    MD_TEST0 = 2'b00,
    MD_HALF = 2'b01,
    MD_SER = 2'b10,
    MD_TEST1 = 2'b11
  } mdd_mode_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_MEAS = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } mdd_rx_t;

  typedef enum logic [2:0] {
    FR_SYNC = 3'b000,
    FR_ADDR = 3'b001,
    FR_REG = 3'b010,
    FR_DATA = 3'b011,
    FR_CRC = 3'b100,
    FR_TXD = 3'b101,
    FR_TXC = 3'b110
  } mdd_fr_t;

endpackage

// File: src/mdd_uart.sv
// Half-duplex byte serial port with start-bit auto-baud.
// Assumes a line idling high and a sync byte whose first bit is one.
`timescale 1ns/1ps
`include "mdd_map.svh"

module mdd_uart import mdd_pkg::*; #(
  parameter int CW = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic autobaud,
  input wire logic rx,
  output logic [7:0] rx_byte,
  output logic rx_stb,
  input wire logic tx_go,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic tx_line,
  output logic tx_oe
);
  localparam logic [CW-1:0] BMIN = CW'(`MDD_BIT_MIN);
  localparam logic [CW-1:0] BMAX = CW'(`MDD_BIT_MAX);

  mdd_rx_t st_r;
  logic rx_q;
  logic [CW-1:0] bit_r;
  logic [CW-1:0] tmr_r;
  logic [CW-1:0] ttmr_r;
  logic [3:0] nb_r;
  logic [3:0] tnb_r;
  logic [7:0] sh_r;
  logic [9:0] tsh_r;

  wire fall = rx_q & ~rx;
  wire tick = (tmr_r == '0);
  wire ttick = (ttmr_r == '0);
  wire meas_ok = (tmr_r >= BMIN) && (tmr_r <= BMAX);

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= RX_IDLE;
      rx_q <= 1'b1;
      bit_r <= BMAX;
      tmr_r <= '0;
      nb_r <= 4'h0;
      sh_r <= 8'h00;
      rx_byte <= 8'h00;
      rx_stb <= 1'b0;
    end else if (clr) begin
      st_r <= RX_IDLE;
      bit_r <= BMAX;
      rx_stb <= 1'b0;
    end else begin
      rx_q <= rx;
      rx_stb <= 1'b0;
      unique case (st_r)
        RX_IDLE: begin
          if (fall) begin
            tmr_r <= autobaud ? '0 : bit_r + (bit_r >> 1);
            st_r <= autobaud ? RX_MEAS : RX_DATA;
            nb_r <= 4'h0;
          end
        end
        RX_MEAS: begin
          if (rx) begin
            if (meas_ok) begin
              bit_r <= tmr_r;
            end
            tmr_r <= tmr_r >> 1;
            st_r <= meas_ok ? RX_DATA : RX_IDLE;
          end else if (tmr_r > BMAX) begin
            st_r <= RX_IDLE;
          end else begin
            tmr_r <= tmr_r + 1'b1;
          end
        end
        RX_DATA: begin
          if (tick) begin
            sh_r <= {rx, sh_r[7:1]};
            tmr_r <= bit_r;
            nb_r <= nb_r + 4'h1;
            if (nb_r == 4'h7) begin
              st_r <= RX_STOP;
            end
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        RX_STOP: begin
          if (tick) begin
            // Framing error drops the byte silently
            rx_byte <= sh_r;
            rx_stb <= rx;
            st_r <= RX_IDLE;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tsh_r <= 10'h3FF;
      tnb_r <= 4'h0;
      ttmr_r <= '0;
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      tx_oe <= 1'b0;
    end else if (clr) begin
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      tx_oe <= 1'b0;
    end else if (!tx_busy) begin
      if (tx_go) begin
        tsh_r <= {1'b1, tx_byte, 1'b0};
        tnb_r <= 4'h0;
        // Measured count is one short; match the receiver's bit time
        ttmr_r <= bit_r;
        tx_busy <= 1'b1;
        tx_line <= 1'b0;
        tx_oe <= 1'b1;
      end
    end else if (ttick) begin
      if (tnb_r == 4'h9) begin
        tx_busy <= 1'b0;
        tx_line <= 1'b1;
        tx_oe <= 1'b0;
      end else begin
        tsh_r <= tsh_r >> 1;
        tx_line <= tsh_r[1];
        tnb_r <= tnb_r + 4'h1;
        ttmr_r <= bit_r;
      end
    end else begin
      ttmr_r <= ttmr_r - 1'b1;
    end
  end

endmodule

// File: src/mdd_pwm.sv
// Signed-duty PWM for one H-bridge with cycle-by-cycle current cut.
// Assumes duty and limit are stable mclk-domain levels.
`timescale 1ns/1ps

module mdd_pwm #(
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic signed [DW-1:0] duty,
  input wire logic limit,
  output logic [1:0] hs,
  output logic [1:0] ls,
  output logic cut
);
  logic [DW-2:0] cnt_r;

  wire neg = duty[DW-1];
  wire [DW-1:0] absd = neg ? DW'(-duty) : duty;
  // Most negative code clamps to full scale
  wire [DW-2:0] mag = absd[DW-1] ? '1 : absd[DW-2:0];
  wire [DW-2:0] top = {{(DW-2){1'b1}}, 1'b0};
  wire on = run && !cut && (cnt_r < mag);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      cut <= 1'b0;
      hs <= 2'b00;
      ls <= 2'b00;
    end else begin
      cnt_r <= (cnt_r == top) ? '0 : cnt_r + 1'b1;
      if (cnt_r == top) begin
        cut <= limit;
      end else if (limit) begin
        cut <= 1'b1;
      end
      if (!run) begin
        hs <= 2'b00;
        ls <= 2'b00;
      end else if (on) begin
        hs <= neg ? 2'b10 : 2'b01;
        ls <= neg ? 2'b01 : 2'b10;
      end else begin
        // Off phase brakes on both low sides
        hs <= 2'b00;
        ls <= 2'b11;
      end
    end
  end

endmodule

// File: verif/mdd_chk_sva.sv
// Pin-level assertions for the motor drive control top.
// Bound to mdd_top; every signal belongs to the mclk domain.
`timescale 1ns/1ps
module mdd_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic io_supply_standby,
  input wire logic serial_mode_select,
  input wire logic mode_select_pin,
  input wire logic enable_pin,
  input wire logic pwm_hs_in,
  input wire logic bridge_a_foot_ocp,
  input wire logic bridge_b_foot_ocp,
  input wire logic ser_tx_oe,
  input wire logic [3:0] hs_gate,
  input wire logic [3:0] ls_gate,
  input wire logic fault_indicator_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Mode pins are registered, so antecedents hold them two cycles
  wire ser_on = io_supply_standby && enable_pin &&
    serial_mode_select && !mode_select_pin;
  wire half = io_supply_standby && !serial_mode_select && mode_select_pin;
  property p_en_off;
    !enable_pin |=> hs_gate == 4'h0 && ls_gate == 4'h0;
  endproperty
  a_en_off: assert property (p_en_off) else $error("gate on");
  property p_fault_indicator_out_clr;
    !enable_pin [*2] |=> !fault_indicator_out;
  endproperty
  a_fault_indicator_out_clr: assert property (p_fault_indicator_out_clr) else $error("fault_indicator_out");
  property p_fault_indicator_out_hold;
    fault_indicator_out && enable_pin && io_supply_standby
      |=> fault_indicator_out;
  endproperty
  a_fault_indicator_out_hold: assert property (p_fault_indicator_out_hold) else $error("drop");
  property p_ocp_a;
    ser_on [*2] ##0 bridge_a_foot_ocp ##1 ser_on [*2] |-> fault_indicator_out;
  endproperty
  a_ocp_a: assert property (p_ocp_a) else $error("ocp a");
  property p_ocp_b;
    ser_on [*2] ##0 bridge_b_foot_ocp ##1 ser_on [*2] |-> fault_indicator_out;
  endproperty
  a_ocp_b: assert property (p_ocp_b) else $error("ocp b");
  property p_ocp_off;
    ser_on [*2] ##0 bridge_a_foot_ocp ##1 ser_on [*2]
      |-> hs_gate == 4'h0 && ls_gate == 4'h0;
  endproperty
  a_ocp_off: assert property (p_ocp_off) else $error("ocp on");
  property p_half_hs;
    (half && !pwm_hs_in) [*2] |=> hs_gate == 4'h0;
  endproperty
  a_half_hs: assert property (p_half_hs) else $error("hs on");
  property p_tx_idle;
    (!serial_mode_select || mode_select_pin) [*2] |-> !ser_tx_oe;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("line");
endmodule
bind mdd_top mdd_chk u_chk (.*);

// File: verif/mdd_line.sv
// Host end of the single-wire serial line, idle level from host_tx.
// Assumes the device drives the wire only while its enable is high.
`timescale 1ns/1ps
module mdd_line (
  input wire logic ser_tx,
  input wire logic ser_tx_oe,
  input wire logic host_tx,
  output logic ser_rx
);
  assign ser_rx = ser_tx_oe ? ser_tx : host_tx;
endmodule

// File: verif/tb_top.sv
// Bench for the motor drive control: registers, PWM, flags, standby.
// Assumes AXI4-Lite answers within 50 cycles.
`timescale 1ns/1ps
module tb_top;
  logic mclk=0, nrst=0, io_supply_standby=1, enable_pin=0, pwm_hs_in=0;
  logic serial_mode_select=1, mode_select_pin=0, bridge_a_pol_1=0;
  logic bridge_a_pol_2=0, addr_bit_low_pin=0, addr_bit_high_pin=1;
  logic bridge_a_foot_ocp=0, bridge_b_foot_ocp=0, s_axi_awvalid=0, host_tx=1;
  logic s_axi_wvalid=0, s_axi_bready=0, s_axi_arvalid=0, s_axi_rready=0;
  logic [7:0] cur_a=0, cur_b=0, s_axi_awaddr=0, s_axi_araddr=0;
  logic [31:0] s_axi_wdata=0;
  logic [3:0] s_axi_wstrb=4'hF;
  wire ser_tx, ser_tx_oe, ser_rx, fault_indicator_out, s_axi_awready;
  wire s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [3:0] hs_gate, ls_gate;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int num_errors=0, checks=0;
  mdd_top #(.FRAME_TO(3000)) uut (.*);
  mdd_line u_line (.ser_tx(ser_tx), .ser_tx_oe(ser_tx_oe),
    .host_tx(host_tx), .ser_rx(ser_rx));
  always #50 mclk = ~mclk;
  task test_done;
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task axi(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [9:0] e);
    int n;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    n = 0;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && s_axi_rvalid !== 1'b1 && n < 50);
    if (w) chk(s_axi_bresp, e[9:8]);
    else chk({s_axi_rresp, s_axi_rdata[7:0]}, e);
    {s_axi_bready, s_axi_rready} <= 2'h0;
    @(posedge mclk);
    if (n >= 50) begin
      num_errors++;
      test_done;
    end
  endtask
  task cnt(input int i, input logic [7:0] e);
    logic [7:0] c;
    c = 8'h00;
    repeat (127) begin
      @(posedge mclk);
      c = c + hs_gate[i];
    end
    chk(c, e);
  endtask
  task t_regs;
    axi(1'b0, 8'h00, 8'h00, 10'h000);
    axi(1'b0, 8'h0C, 8'h00, 10'h0FF);
    axi(1'b0, 8'h14, 8'h00, 10'h200);
    axi(1'b1, 8'h0C, 8'h40, 10'h000);
    axi(1'b0, 8'h0C, 8'h00, 10'h040);
    axi(1'b1, 8'h10, 8'hFF, 10'h000);
    axi(1'b0, 8'h10, 8'h00, 10'h0A0);
    io_supply_standby <= 1'b0;
    @(posedge mclk);
    io_supply_standby <= 1'b1;
    @(posedge mclk);
    axi(1'b0, 8'h0C, 8'h00, 10'h0FF);
  endtask
  task t_pwm;
    axi(1'b1, 8'h00, 8'h01, 10'h000);
    axi(1'b1, 8'h04, 8'h14, 10'h000);
    bridge_a_pol_2 <= 1'b1;
    enable_pin <= 1'b1;
    repeat (130) @(posedge mclk);
    cnt(0, 8'h14);
    cnt(1, 8'h00);
    cnt(2, 8'h14);
    axi(1'b1, 8'h04, 8'hEC, 10'h000);
    repeat (130) @(posedge mclk);
    cnt(1, 8'h14);
    cnt(3, 8'h14);
  endtask
  task t_lim;
    axi(1'b1, 8'h0C, 8'h40, 10'h000);
    cur_a <= 8'hFF;
    repeat (200) @(posedge mclk);
    chk(fault_indicator_out, 1'b1);
    axi(1'b0, 8'h10, 8'h00, 10'h0AE);
    cnt(1, 8'h00);
    cnt(3, 8'h00);
    cur_a <= 8'h00;
    enable_pin <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({hs_gate, ls_gate, fault_indicator_out}, 9'h000);
    // Limiter cut lasts to the end of its PWM period
    repeat (130) @(posedge mclk);
    axi(1'b0, 8'h10, 8'h00, 10'h0A0);
  endtask
  task t_ocp;
    for (int i = 0; i < 2; i++) begin
      enable_pin <= 1'b1;
      repeat (3) @(posedge mclk);
      {bridge_b_foot_ocp, bridge_a_foot_ocp} <= 2'b01 << i;
      @(posedge mclk);
      {bridge_b_foot_ocp, bridge_a_foot_ocp} <= 2'b00;
      repeat (3) @(posedge mclk);
      chk({hs_gate, ls_gate, fault_indicator_out}, 9'h001);
      axi(1'b0, 8'h10, 8'h00, 10'h0A1);
      enable_pin <= 1'b0;
      repeat (3) @(posedge mclk);
      axi(1'b0, 8'h10, 8'h00, 10'h0A0);
    end
  endtask
  task t_half;
    {serial_mode_select, mode_select_pin} <= 2'b01;
    {bridge_a_pol_2, bridge_a_pol_1} <= 2'b01;
    pwm_hs_in <= 1'b1;
    enable_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({hs_gate, ls_gate}, 8'h96);
    pwm_hs_in <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({hs_gate, ls_gate}, 8'h06);
    enable_pin <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({hs_gate, ls_gate}, 8'h00);
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c,
    input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  // Host sends 8N1 at 40 cycles a bit, 250k baud
  task sbyte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_tx <= f[i];
      repeat (40) @(posedge mclk);
    end
  endtask
  task sframe(input logic [7:0] a, input logic [7:0] r,
    input logic [7:0] d, input logic [7:0] x);
    sbyte(8'h55);
    sbyte(a);
    sbyte(r);
    sbyte(d);
    sbyte(crc(crc(crc(crc(8'h00, 8'h55), a), r), d) ^ x);
  endtask
  task t_ser;
    sframe(8'h82, 8'h03, 8'h33, 8'h00);
    axi(1'b0, 8'h0C, 8'h00, 10'h033);
    sframe(8'h82, 8'h03, 8'h44, 8'h01);
    axi(1'b0, 8'h0C, 8'h00, 10'h033);
    sframe(8'h81, 8'h03, 8'h55, 8'h00);
    axi(1'b0, 8'h0C, 8'h00, 10'h033);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_regs;
    t_ser;
    t_pwm;
    t_lim;
    t_ocp;
    t_half;
    test_done;
  end
endmodule
